//--- inc/pfs_pkg.sv
// Purpose: constants for the power feedback and input select block
// Assumes: apb with 32-bit data, byte addresses
// Notes: percent values are held in hundredths of a percent
`default_nettype none
package pfs_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ROLE = 8'h04;
   localparam logic [7:0] ADDR_NOMV = 8'h08;
   localparam logic [7:0] ADDR_NOMI = 8'h0C;
   localparam logic [7:0] ADDR_ILIM = 8'h10;
   localparam logic [7:0] ADDR_SETPT = 8'h14;
   localparam logic [7:0] ADDR_AIN1 = 8'h18;
   localparam logic [7:0] ADDR_AIN2 = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [7:0] ADDR_FBK = 8'h24;
   // control field positions
   localparam int CTRL_FB_LSB = 0;     // feedback mode, 3 bits
   localparam int CTRL_LEG_LSB = 3;    // measured legs, 2 bits
   localparam int CTRL_PEAK = 5;       // peak current limit
   localparam int CTRL_FIRE_PA = 6;    // configured phase-angle firing
   localparam int CTRL_LOG = 7;        // configured logging
   localparam int CTRL_BAKE = 8;       // configured bakeout
   localparam int CTRL_LOCAL = 9;      // local set point chosen
   localparam int CTRL_ALM_LSB = 10;   // alarm selection mask, 4 bits
   localparam int ALM_HB = 0;
   localparam int ALM_SC = 1;
   localparam int ALM_ILIM = 2;
   localparam int ALM_GEN = 3;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0208;
   localparam logic [15:0] NOM_RST = 16'h0001;
   localparam logic [15:0] AIN_HI_RST = 16'hFFFF;
   // full scale: 100 percent in hundredths
   localparam logic [15:0] PCT_FULL = 16'h2710;
   // feedback modes
   typedef enum logic [2:0] {
      FB_VOLT = 3'b000,
      FB_VSQ = 3'b001,
      FB_POWER = 3'b010,
      FB_ISQ = 3'b011,
      FB_CURR = 3'b100,
      FB_EXT = 3'b101,
      FB_NONE = 3'b110
   } pfs_fb_t;
   // digital input roles
   typedef enum logic [3:0] {
      ROLE_NONE = 4'b0000,
      ROLE_ENABLE = 4'b0001,
      ROLE_VFB = 4'b0010,
      ROLE_LOCREM = 4'b0011,
      ROLE_PHASE = 4'b0100,
      ROLE_SPSEL = 4'b0101,
      ROLE_LOG = 4'b0110,
      ROLE_BAKE = 4'b0111,
      ROLE_ARST = 4'b1000,
      ROLE_FOLLOW = 4'b1001
   } pfs_role_t;
endpackage
`default_nettype wire

//--- core/pfs_core.sv
// Purpose: feedback selection, current limit, input roles and alarm relay
// Assumes: measured values arrive synchronous to clock_i, refreshed slowly
// Notes: loop outputs come from the pi loops outside this block
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`default_nettype none
module pfs_core #(
   parameter bit HAS_ILIM = 1'b1, // model includes current limiting
   parameter int DW = 16          // measurement width
) (
   input wire logic clock_i,           // 100 MHz clock
   input wire logic nrst_i,            // async reset, active low
   input wire logic psel_i,            // apb select
   input wire logic penable_i,         // apb enable
   input wire logic pwrite_i,          // apb direction
   input wire logic [7:0] paddr_i,     // apb byte address
   input wire logic [31:0] pwdata_i,   // apb write data
   output logic [31:0] prdata_o,       // apb read data
   output logic pready_o,              // apb ready
   output logic pslverr_o,             // apb error
   input wire logic [DW-1:0] vrms_i,   // rms load voltage
   input wire logic [DW-1:0] irms1_i,  // rms current leg 1
   input wire logic [DW-1:0] irms2_i,  // rms current leg 2
   input wire logic [DW-1:0] irms3_i,  // rms current leg 3
   input wire logic [DW-1:0] ipeak_i,  // peak load current
   input wire logic [DW-1:0] ain1_i,   // analog input 1 raw
   input wire logic [DW-1:0] ain2_i,   // analog input 2 raw
   input wire logic [15:0] demand_i,   // demand loop output
   input wire logic [15:0] limit_i,    // limit loop output
   input wire logic din1_i,            // digital input 1
   input wire logic din2_i,            // digital input 2
   input wire logic panel_btn_i,       // local/remote button pulse
   input wire logic hb_cond_i,         // heater break seen
   input wire logic sc_cond_i,         // short circuit seen
   input wire logic gen_alarm_i,       // other alarm conditions
   input wire logic overtemp_i,        // heat-sink too hot
   input wire logic aux_pwr_i,         // auxiliary power present
   output logic [15:0] feedback_o,     // selected feedback
   output logic [15:0] setpoint_o,     // chosen set point
   output logic [15:0] output_o,       // power output command
   output logic phase_angle_o,         // phase-angle firing
   output logic logging_o,             // data logging enable
   output logic bakeout_o,             // bakeout enable
   output logic hb_det_en_o,           // heater break detect on
   output logic sc_det_en_o,           // short detect on
   output logic relay_o                // alarm relay energised
);
   if (DW < 8 || DW > 16) begin : g_chk
      $error("pfs_core: DW out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_reg;       // mode and option bits
   logic [7:0] role_reg;        // [3:0] input 1 role, [7:4] input 2
   logic [15:0] nomv_reg;       // nominal voltage
   logic [15:0] nomi_reg;       // nominal current
   logic [15:0] ilim_reg;       // current limit set point
   logic [15:0] setpt_reg;      // keypad/communication set point
   logic [31:0] ain_reg [2];    // per channel: hi[31:16], lo[15:0]
   logic local_reg;             // source chosen by panel button
   logic hb_reg;                // latched heater break alarm
   logic [15:0] ain_pct [2];    // scaled analog inputs
   logic [15:0] fbk_next;
   logic wr_en;
   logic rd_ok;
   logic [31:0] rd_next;

   // role resolution: input two wins where both share a role
   function automatic logic [1:0] role_hit(input logic [7:0] r, input logic d1,
         input logic d2, input logic [3:0] want);
      logic [1:0] res;
      res = 2'b00;
      if (want == 4'(pfs_pkg::ROLE_NONE)) begin
         res = 2'b00;
      end else if (r[7:4] == want) begin
         res = {1'b1, d2};
      end else if (r[3:0] == want) begin
         res = {1'b1, d1};
      end
      return res; // [1] role present, [0] its level
   endfunction

   logic [1:0] r_en, r_vfb, r_lr, r_pa, r_sps, r_log, r_bake, r_arst, r_fol;
   always_comb begin
      r_en = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_ENABLE));
      r_vfb = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_VFB));
      r_lr = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_LOCREM));
      r_pa = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_PHASE));
      r_sps = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_SPSEL));
      r_log = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_LOG));
      r_bake = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_BAKE));
      r_arst = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_ARST));
      r_fol = role_hit(role_reg, din1_i, din2_i, 4'(pfs_pkg::ROLE_FOLLOW));
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait-free access, answer ready in the access cycle
   assign wr_en = psel_i && penable_i && pwrite_i && pready_o;

   // read mux and address check
   always_comb begin
      rd_ok = 1'b1;
      rd_next = 32'h0000_0000;
      case (paddr_i)
         pfs_pkg::ADDR_CTRL: rd_next = ctrl_reg;
         pfs_pkg::ADDR_ROLE: rd_next = {24'h00_0000, role_reg};
         pfs_pkg::ADDR_NOMV: rd_next = {16'h0000, nomv_reg};
         pfs_pkg::ADDR_NOMI: rd_next = {16'h0000, nomi_reg};
         pfs_pkg::ADDR_ILIM: rd_next = {16'h0000, ilim_reg};
         pfs_pkg::ADDR_SETPT: rd_next = {16'h0000, setpt_reg};
         pfs_pkg::ADDR_AIN1: rd_next = ain_reg[0];
         pfs_pkg::ADDR_AIN2: rd_next = ain_reg[1];
         pfs_pkg::ADDR_STAT: rd_next = {22'h00_0000, local_reg, hb_reg, relay_o,
            phase_angle_o, logging_o, bakeout_o, din2_i, din1_i, ain_pct[1][15], 1'b0};
         pfs_pkg::ADDR_FBK: rd_next = {16'h0000, feedback_o};
         default: rd_ok = 1'b0; // unmapped: slave error
      endcase
   end

   // answer flops: ready one cycle after setup
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && !penable_i;
         prdata_o <= (psel_i && !penable_i && !pwrite_i) ? rd_next : 32'h0000_0000;
         // status and feedback words are read-only
         pslverr_o <= psel_i && !penable_i && (!rd_ok || (pwrite_i &&
            (paddr_i == pfs_pkg::ADDR_STAT || paddr_i == pfs_pkg::ADDR_FBK)));
      end
   end

   // configuration writes
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_reg <= pfs_pkg::CTRL_RST;
         role_reg <= 8'h00;
         nomv_reg <= pfs_pkg::NOM_RST;
         nomi_reg <= pfs_pkg::NOM_RST;
         ilim_reg <= 16'hFFFF;
         setpt_reg <= 16'h0000;
         ain_reg[0] <= {pfs_pkg::AIN_HI_RST, 16'h0000};
         ain_reg[1] <= {pfs_pkg::AIN_HI_RST, 16'h0000};
      end else if (wr_en) begin
         case (paddr_i)
            pfs_pkg::ADDR_CTRL: ctrl_reg <= {18'h0_0000, pwdata_i[13:0]};
            pfs_pkg::ADDR_ROLE: role_reg <= pwdata_i[7:0];
            pfs_pkg::ADDR_NOMV: nomv_reg <= pwdata_i[15:0];
            pfs_pkg::ADDR_NOMI: nomi_reg <= pwdata_i[15:0];
            pfs_pkg::ADDR_ILIM: ilim_reg <= pwdata_i[15:0];
            pfs_pkg::ADDR_SETPT: setpt_reg <= pwdata_i[15:0];
            pfs_pkg::ADDR_AIN1: ain_reg[0] <= pwdata_i;
            pfs_pkg::ADDR_AIN2: ain_reg[1] <= pwdata_i;
            default: ;
         endcase
      end
   end

   // panel button toggles the source, ignored while an input owns it
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         local_reg <= 1'b1;
      end else if (panel_btn_i && !r_lr[1]) begin
         local_reg <= !local_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // analog scaling, one instance per channel
   for (genvar c = 0; c < 2; c++) begin : g_ain
      logic [15:0] lo, hi, raw;
      logic [31:0] q;
      assign lo = ain_reg[c][15:0];
      assign hi = ain_reg[c][31:16];
      assign raw = (c == 0) ? 16'(ain1_i) : 16'(ain2_i);
      // a degenerate range reads as zero rather than dividing by zero
      assign q = (hi > lo) ? (32'(raw - lo) * 32'(pfs_pkg::PCT_FULL)) / 32'(hi - lo)
                           : 32'h0000_0000;
      assign ain_pct[c] = (raw <= lo || hi <= lo) ? 16'h0000 :
                          (raw >= hi) ? pfs_pkg::PCT_FULL : q[15:0];
   end

   ////////////////////////////////////////////////////////////////////
   // feedback: numerator over denominator, one shared divider
   logic [2:0] fb_mode;
   logic [1:0] legs;
   logic [17:0] isum;
   logic [63:0] num, den, quo;
   always_comb begin
      fb_mode = r_vfb[1] && r_vfb[0] ? 3'(pfs_pkg::FB_VOLT)
                : ctrl_reg[pfs_pkg::CTRL_FB_LSB +: 3];
      legs = ctrl_reg[pfs_pkg::CTRL_LEG_LSB +: 2];
      if (legs == 2'd0) begin
         legs = 2'd1; // zero legs treated as one
      end
      isum = 18'(irms1_i) + ((legs >= 2'd2) ? 18'(irms2_i) : 18'h0_0000)
             + ((legs == 2'd3) ? 18'(irms3_i) : 18'h0_0000);
      num = 64'h0000_0000_0000_0000;
      den = 64'h0000_0000_0000_0001;
      case (fb_mode)
         pfs_pkg::FB_VOLT: begin
            num = 64'(vrms_i) * 64'(pfs_pkg::PCT_FULL);
            den = 64'(nomv_reg);
         end
         pfs_pkg::FB_VSQ: begin
            num = 64'(vrms_i) * 64'(vrms_i) * 64'(pfs_pkg::PCT_FULL);
            den = 64'(nomv_reg) * 64'(nomv_reg);
         end
         pfs_pkg::FB_POWER: begin
            num = 64'(vrms_i) * 64'(isum) * 64'(pfs_pkg::PCT_FULL);
            den = 64'(legs) * 64'(nomv_reg) * 64'(nomi_reg);
         end
         pfs_pkg::FB_ISQ: begin
            // averaging happens before squaring
            num = 64'(isum) * 64'(isum) * 64'(pfs_pkg::PCT_FULL);
            den = 64'(legs) * 64'(legs) * 64'(nomi_reg) * 64'(nomi_reg);
         end
         pfs_pkg::FB_CURR: begin
            num = 64'(isum) * 64'(pfs_pkg::PCT_FULL);
            den = 64'(legs) * 64'(nomi_reg);
         end
         default: ;
      endcase
      quo = (den == 64'h0) ? 64'hFFFF : num / den;
      if (fb_mode == 3'(pfs_pkg::FB_EXT)) begin
         fbk_next = ain_pct[1];
      end else if (fb_mode == 3'(pfs_pkg::FB_NONE)) begin
         fbk_next = setpoint_o; // reads as matched, loop idles
      end else begin
         fbk_next = (quo > 64'hFFFF) ? 16'hFFFF : quo[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // set point source and feedback flops
   logic use_local;
   assign use_local = r_lr[1] ? r_lr[0] : local_reg;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         setpoint_o <= 16'h0000;
         feedback_o <= 16'h0000;
      end else begin
         if (use_local) begin
            setpoint_o <= setpt_reg;
         end else begin
            setpoint_o <= (r_sps[1] && r_sps[0]) ? ain_pct[1] : ain_pct[0];
         end
         feedback_o <= fbk_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output command: loop minimum, then gating
   logic [15:0] dem, lim_min;
   logic lim_active, peak_over;
   always_comb begin
      // no feedback: on-time follows the set point directly
      dem = (fb_mode == 3'(pfs_pkg::FB_NONE)) ? setpoint_o : demand_i;
      if (r_fol[1]) begin
         dem = r_fol[0] ? pfs_pkg::PCT_FULL : 16'h0000;
      end
      lim_active = HAS_ILIM && !ctrl_reg[pfs_pkg::CTRL_PEAK] && (limit_i < dem);
      lim_min = lim_active ? limit_i : dem;
      peak_over = HAS_ILIM && ctrl_reg[pfs_pkg::CTRL_PEAK] && (16'(ipeak_i) > ilim_reg);
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         output_o <= 16'h0000;
         phase_angle_o <= 1'b0;
      end else begin
         output_o <= (r_en[1] && !r_en[0]) ? 16'h0000 : lim_min;
         // limiting always fires by phase angle
         phase_angle_o <= ctrl_reg[pfs_pkg::CTRL_FIRE_PA] || (r_pa[1] && r_pa[0])
                          || peak_over || lim_active;
      end
   end

   // logging and bakeout overrides
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         logging_o <= 1'b0;
         bakeout_o <= 1'b0;
      end else begin
         logging_o <= r_log[1] ? r_log[0] : ctrl_reg[pfs_pkg::CTRL_LOG];
         bakeout_o <= r_bake[1] ? r_bake[0] : ctrl_reg[pfs_pkg::CTRL_BAKE];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // alarms and relay
   logic [3:0] alm_sel;
   logic arst_on, alarm_any;
   assign alm_sel = ctrl_reg[pfs_pkg::CTRL_ALM_LSB +: 4];
   assign arst_on = r_arst[1] && r_arst[0];

   // heater break latch: the held reset input keeps it clear
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hb_reg <= 1'b0;
      end else if (arst_on) begin
         hb_reg <= 1'b0;
      end else if (hb_cond_i && alm_sel[pfs_pkg::ALM_HB]) begin
         hb_reg <= 1'b1;
      end
   end

   assign alarm_any = hb_reg || (sc_cond_i && alm_sel[pfs_pkg::ALM_SC])
                      || (lim_active && alm_sel[pfs_pkg::ALM_ILIM])
                      || (gen_alarm_i && alm_sel[pfs_pkg::ALM_GEN]);

   // overtemperature beats both selection and the reset input
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         relay_o <= 1'b0;
         hb_det_en_o <= 1'b0;
         sc_det_en_o <= 1'b0;
      end else begin
         relay_o <= aux_pwr_i && !overtemp_i && (arst_on || !alarm_any);
         hb_det_en_o <= alm_sel[pfs_pkg::ALM_HB];
         sc_det_en_o <= alm_sel[pfs_pkg::ALM_SC];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_apb_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_hot;
      overtemp_i;
   endsequence

   AST_APB_READY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      s_apb_setup |=> pready_o)
      else $error("ready missing after setup");
   AST_OVERTEMP: assert property (@(posedge clock_i) disable iff (!nrst_i)
      s_hot |=> !relay_o)
      else $error("relay energised while heat sink hot");
   AST_NO_AUX: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !aux_pwr_i |=> !relay_o)
      else $error("relay energised without aux power");
   AST_GATE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (r_en[1] && !r_en[0]) |=> output_o == 16'h0000)
      else $error("output not gated off");
   AST_MIN: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !(r_en[1] && !r_en[0]) |=> output_o <= $past(dem))
      else $error("output above demand");
   AST_PA_ROLE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (r_pa[1] && r_pa[0]) |=> phase_angle_o)
      else $error("phase angle not forced");
   AST_PEAK: assert property (@(posedge clock_i) disable iff (!nrst_i)
      peak_over |=> phase_angle_o)
      else $error("peak over limit without phase angle");
   AST_ARST: assert property (@(posedge clock_i) disable iff (!nrst_i)
      arst_on |=> !hb_reg)
      else $error("heater break not cleared");
   AST_VFB: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (r_vfb[1] && r_vfb[0]) |-> fb_mode == 3'(pfs_pkg::FB_VOLT))
      else $error("voltage feedback override lost");
   AST_HB_SEL: assert property (@(posedge clock_i) disable iff (!nrst_i)
      (!alm_sel[pfs_pkg::ALM_HB] && !hb_reg) |=> !hb_reg)
      else $error("heater break latched while unselected");
endmodule // pfs_core
`default_nettype wire

//--- tb/pfs_plc_model.sv
// Purpose: far-side controller driving the digital and analog inputs
// Assumes: commanded levels change just after a rising edge
// Notes: slow_i adds a cycle of lag, like a sluggish plc scan
`default_nettype none
module pfs_plc_model (
   input wire logic clock_i,          // bench clock
   input wire logic slow_i,           // answer one cycle late
   input wire logic [1:0] want_din_i, // wanted din2, din1 levels
   input wire logic [15:0] want_a1_i, // wanted analog 1 raw
   input wire logic [15:0] want_a2_i, // wanted analog 2 raw
   output logic [1:0] din_o,          // digital inputs to block
   output logic [15:0] ain1_o,        // analog 1 to block
   output logic [15:0] ain2_o         // analog 2 to block
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [33:0] lag_reg; // lagged copy for the slow answer
   // a slow controller shows its new levels one cycle later
   always_ff @(posedge clock_i) begin
      lag_reg <= {want_din_i, want_a1_i, want_a2_i};
   end
   assign {din_o, ain1_o, ain2_o} = slow_i ? lag_reg : {want_din_i, want_a1_i, want_a2_i};
endmodule // pfs_plc_model
`default_nettype wire

//--- tb/pfs_core_test.sv
// Purpose: self-checking bench for the feedback and input select block
// Assumes: outputs settle within two cycles of their inputs
// Notes: every wait for apb ready is bounded by the watchdog
`default_nettype none
`define PFS_EQ(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; $display("unexpected %0t: %h vs %h", $time, g, e); end end
module pfs_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i, nrst_i, psel, penable, pwrite, pready, pslverr, btn, hb, sc, gen, ot, aux, slow, er;
   logic pa, lg, bk, hbe, sce, rly;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] vrms, i1, i2, i3, ipk, a1, a2, ain1, ain2, dem, lim, fb, sp, outp;
   logic [1:0] wdin, din;
   int errors, checks_done;
   pfs_plc_model pfs_plc_model_inst (.clock_i(clock_i), .slow_i(slow), .want_din_i(wdin), .want_a1_i(a1),
      .want_a2_i(a2), .din_o(din), .ain1_o(ain1), .ain2_o(ain2));
   pfs_core pfs_core_inst (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .vrms_i(vrms), .irms1_i(i1), .irms2_i(i2), .irms3_i(i3), .ipeak_i(ipk),
      .ain1_i(ain1), .ain2_i(ain2), .demand_i(dem), .limit_i(lim), .din1_i(din[0]), .din2_i(din[1]),
      .panel_btn_i(btn), .hb_cond_i(hb), .sc_cond_i(sc), .gen_alarm_i(gen), .overtemp_i(ot),
      .aux_pwr_i(aux), .feedback_o(fb), .setpoint_o(sp), .output_o(outp), .phase_angle_o(pa),
      .logging_o(lg), .bakeout_o(bk), .hb_det_en_o(hbe), .sc_det_en_o(sce), .relay_o(rly));
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer, held until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // outputs lag inputs by two cycles, the slow partner adds one
   task automatic settle;
      repeat (4) @(posedge clock_i);
   endtask
   task automatic mode(input logic [31:0] c, input logic [15:0] v, input logic [15:0] e);
      apb(1'b1, pfs_pkg::ADDR_CTRL, c);
      vrms <= v;
      settle();
      `PFS_EQ(fb, e)
   endtask
   task automatic role(input logic [31:0] r, input logic [1:0] d);
      apb(1'b1, pfs_pkg::ADDR_ROLE, r);
      wdin <= d;
      settle();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // control reset value, then a refused unmapped read
   task automatic t_regs;
      apb(1'b0, pfs_pkg::ADDR_CTRL, 32'h0000_0000);
      `PFS_EQ(rd, pfs_pkg::CTRL_RST)
      apb(1'b0, 8'h28, 32'h0000_0000);
      `PFS_EQ(er, 1'b1)
   endtask
   // every feedback mode except none, current modes with two and three legs
   task automatic t_fb;
      apb(1'b1, pfs_pkg::ADDR_NOMV, 32'h0000_03E8);
      apb(1'b1, pfs_pkg::ADDR_NOMI, 32'h0000_0064);
      apb(1'b1, pfs_pkg::ADDR_AIN2, 32'h07D0_0190);
      mode(32'h0000_0000, 16'h01F4, 16'h1388);
      mode(32'h0000_0001, 16'h01F4, 16'h09C4);
      mode(32'h0000_0012, 16'h03E8, 16'h1D4C);
      mode(32'h0000_0013, 16'h03E8, 16'h15F9);
      mode(32'h0000_001C, 16'h03E8, pfs_pkg::PCT_FULL);
      mode(32'h0000_0005, 16'h03E8, 16'h1388);
   endtask
   // open loop, rms and peak limit, smaller loop wins
   task automatic t_loop;
      apb(1'b1, pfs_pkg::ADDR_SETPT, 32'h0000_0BB8);
      mode(32'h0000_0006, 16'h03E8, 16'h0BB8);
      `PFS_EQ(outp, 16'h0BB8)
      mode(32'h0000_0000, 16'h03E8, pfs_pkg::PCT_FULL);
      `PFS_EQ(outp, 16'h1770)
      `PFS_EQ(pa, 1'b1)
      lim <= 16'h2328;
      settle();
      `PFS_EQ(outp, 16'h1F40)
      `PFS_EQ(pa, 1'b0)
      apb(1'b1, pfs_pkg::ADDR_ILIM, 32'h0000_03E8);
      ipk <= 16'h07D0;
      mode(32'h0000_0020, 16'h03E8, pfs_pkg::PCT_FULL);
      `PFS_EQ(pa, 1'b1)
      ipk <= 16'h01F4;
      settle();
      `PFS_EQ(pa, 1'b0)
   endtask
   // digital input roles, with the partner answering late
   task automatic t_roles;
      slow <= 1'b1;
      mode(32'h0000_0180, 16'h03E8, pfs_pkg::PCT_FULL);
      role(32'h0000_0011, 2'b01);
      `PFS_EQ(outp, 16'h0000)
      role(32'h0000_0000, 2'b01);
      `PFS_EQ(outp, 16'h1F40)
      role(32'h0000_0004, 2'b01);
      `PFS_EQ(pa, 1'b1)
      role(32'h0000_0076, 2'b00);
      `PFS_EQ({lg, bk}, 2'b00)
      role(32'h0000_0020, 2'b10);
      mode(32'h0000_0004, 16'h03E8, pfs_pkg::PCT_FULL);
      role(32'h0000_0009, 2'b00);
      `PFS_EQ(outp, 16'h0000)
      role(32'h0000_0009, 2'b01);
      `PFS_EQ(outp, 16'h2328)
      apb(1'b1, pfs_pkg::ADDR_AIN1, 32'h03E8_0000);
      a2 <= 16'h0320;
      role(32'h0000_0053, 2'b10);
      `PFS_EQ(sp, 16'h09C4)
      role(32'h0000_0053, 2'b01);
      btn <= 1'b1;
      @(posedge clock_i);
      btn <= 1'b0;
      settle();
      `PFS_EQ(sp, 16'h0BB8)
      // the press above must have left the panel source alone
      role(32'h0000_0000, 2'b00);
      `PFS_EQ(sp, 16'h0BB8)
      a1 <= 16'h01F4;
      btn <= 1'b1;
      @(posedge clock_i);
      btn <= 1'b0;
      settle();
      `PFS_EQ(sp, 16'h1388)
      slow <= 1'b0;
   endtask
   // alarm selection, break latch, clear input, heat-sink
   task automatic t_alarm;
      apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h0000_0400);
      role(32'h0000_0008, 2'b00);
      `PFS_EQ({hbe, sce, rly}, 3'b101)
      hb <= 1'b1;
      settle();
      `PFS_EQ(rly, 1'b0)
      role(32'h0000_0008, 2'b01);
      `PFS_EQ(rly, 1'b1)
      apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h0000_0800);
      sc <= 1'b1;
      role(32'h0000_0000, 2'b00);
      `PFS_EQ({hbe, sce, rly}, 3'b010)
      apb(1'b1, pfs_pkg::ADDR_CTRL, 32'h0000_0000);
      ot <= 1'b1;
      settle();
      `PFS_EQ({hbe, rly}, 2'b00)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      if (errors == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clock_i);
      errors++;
      complete_run();
   end
   initial begin
      {nrst_i, psel, penable, pwrite, btn, hb, sc, gen, ot, slow, errors, checks_done} = '0;
      {paddr, pwdata, vrms, ipk, a1, wdin} = '0;
      {i1, i2, i3, a2, dem, lim} = {16'h0032, 16'h0064, 16'h0096, 16'h04B0, 16'h1F40, 16'h1770};
      aux = 1'b1;
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      t_regs();
      t_fb();
      t_loop();
      t_roles();
      t_alarm();
      complete_run();
   end
endmodule // pfs_core_test
`default_nettype wire
